/* File: src/external_bus_pin_control.sv */
// External bus interface, mode pin muxing, clocks, reset and nonmaskable edge detect.
//
// Function
// - External accesses drive the sixteen-bit address on the address output pins.
// - Data moves on an eight-bit two-way bus: driven here on writes, from outside on reads.
// - The read strobe is low during an external read and high otherwise.
// - The write strobe is low during an external write and high otherwise.
// - The address strobe is low while the address bus carries a valid address.
// - In expanded modes the high-page select is low for accesses from FF00 upward.
// - A wait request from the far side stretches the off-chip cycle with stall states.
// - The nonmaskable input is top priority, triggered on the edge a control bit selects.
// - A low reset input flags reset, idles the bus sequencer and holds the clocks; in expanded modes the address pins stay driven.
// - A low standby input moves the chip into hardware standby.
// - The system clock runs at half the oscillator input frequency.
// - The system clock is driven out on its own pin.
// - An E clock is driven out on its own pin.
`timescale 1ns/1ps
module external_bus_pin_control #(
    parameter int E_DIV = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire logic hw_standby_n,
    input wire logic boot_cfg_hi,
    input wire logic boot_cfg_lo,
    input wire logic nonmask_pin,
    input wire logic nonmask_edge_select,
    input wire logic nonmask_ack,
    output logic nonmask_req,
    input wire logic [7:0] addr_low_port_out,
    input wire ext_bus_pkg::bus_req_t cpu_req,
    output ext_bus_pkg::bus_rsp_t cpu_rsp,
    output logic [15:0] addr_out_bus,
    output logic [15:0] addr_out_oe,
    input wire logic [7:0] bidir_byte_bus_in,
    output logic [7:0] bidir_byte_bus_out,
    output logic [7:0] bidir_byte_bus_oe,
    input wire logic wait_req_n,
    output logic rd_strobe_n,
    output logic wr_strobe_n,
    output logic addr_valid_strobe_n,
    output logic high_page_select_n,
    output logic bus_ctrl_oe,
    output logic sys_clk_out,
    output logic e_clk_out,
    output logic chip_in_reset,
    output logic chip_in_standby,
    output logic [1:0] mode_q
);
    import ext_bus_pkg::*;

    bus_state_t state_q;
    logic run;
    logic sys_tick;
    logic expanded;
    logic high_page;
    logic nm_prev_q;
    logic access_wr_q;
    logic [15:0] access_addr_q;
    logic [7:0] access_wdata_q;
    logic strobe_phase;
    logic pins_live;
    logic strobe_live;
    logic port_lends_low;

    // Decodes whether an address lies in the high page.
    function automatic logic in_high_page(input logic [15:0] a);
        return a[HIGH_PAGE_MSB:HIGH_PAGE_LSB] == HIGH_PAGE_BASE[HIGH_PAGE_MSB:HIGH_PAGE_LSB];
    endfunction : in_high_page

    // True in the phases in which the strobes and the data drive are active.
    function automatic logic in_strobe_phase(input bus_state_t s);
        return (s == ST_DATA) || (s == ST_STALL);
    endfunction : in_strobe_phase

    // ==========================================================================
    // Reset, standby and mode
    // ==========================================================================
    // Standby and reset both idle the bus sequencer and hold the clocks; standby also parks the pins.
    assign chip_in_reset = ~reset_pin_n;
    assign chip_in_standby = ~hw_standby_n;
    assign run = reset_pin_n & hw_standby_n;
    assign expanded = (mode_q == MODE_EXP_NOROM) || (mode_q == MODE_EXP_ROM);

    // The mode pins are latched while the reset pin is low, so they are stable afterwards.
    // A mode change therefore takes effect only through a pin reset, never in mid-access.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mode_q <= MODE_SINGLE;
        end else if (!reset_pin_n) begin
            mode_q <= {boot_cfg_hi, boot_cfg_lo};
        end
    end

    // ==========================================================================
    // Clock outputs
    // ==========================================================================
    // The E clock rate is a parameter because the needs of the far side differ per board.
    clock_gen #(
        .E_DIV(E_DIV)
    ) u_clock_gen (
        .mclk(mclk),
        .reset(reset),
        .run(run),
        .sys_clk_out(sys_clk_out),
        .sys_tick(sys_tick),
        .e_clk_out(e_clk_out)
    );

    // ==========================================================================
    // Nonmaskable edge detect
    // ==========================================================================
    // The request is sticky until acknowledged; a new edge in the ack cycle wins.
    // The previous level follows the pin in reset too, so a release gives no false edge.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            nm_prev_q <= 1'b1;
            nonmask_req <= 1'b0;
        end else if (!reset_pin_n) begin
            nm_prev_q <= nonmask_pin;
            nonmask_req <= 1'b0;
        end else begin
            nm_prev_q <= nonmask_pin;
            if (nonmask_edge_select ? (nonmask_pin & ~nm_prev_q)
                                    : (~nonmask_pin & nm_prev_q)) begin
                nonmask_req <= 1'b1;
            end else if (nonmask_ack) begin
                nonmask_req <= 1'b0;
            end
        end
    end

    // ==========================================================================
    // Bus sequencer
    // ==========================================================================
    // Idle takes a request, then address phase, data phase, stretched by stall states.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            access_wr_q <= 1'b0;
            access_addr_q <= 16'h0000;
            access_wdata_q <= 8'h00;
            cpu_rsp <= '0;
        end else if (!run) begin
            state_q <= ST_IDLE;
            cpu_rsp <= '0;
        end else begin
            // Ready is a one-cycle pulse; the read byte stays in its register until the next read, a pin reset or standby.
            cpu_rsp.ready <= 1'b0;
            if (sys_tick) begin
                case (state_q)
                    ST_IDLE: begin
                        // The request is copied so the pins stay steady if the caller moves on.
                        if (cpu_req.req && expanded) begin
                            access_wr_q <= cpu_req.wr;
                            access_addr_q <= cpu_req.addr;
                            access_wdata_q <= cpu_req.wdata;
                            state_q <= ST_ADDR;
                        end
                    end
                    ST_ADDR: begin
                        state_q <= ST_DATA;
                    end
                    ST_DATA, ST_STALL: begin
                        // Wait is looked at only on a tick, so a glitch between ticks is ignored.
                        if (!wait_req_n) begin
                            state_q <= ST_STALL;
                        end else begin
                            cpu_rsp.ready <= 1'b1;
                            cpu_rsp.rdata <= access_wr_q ? cpu_rsp.rdata : bidir_byte_bus_in;
                            state_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================================
    // Pin drive
    // ==========================================================================
    // Qualifiers shared by the strobes, the data drive and the address pins.
    assign strobe_phase = in_strobe_phase(state_q);
    assign pins_live = expanded & hw_standby_n;
    assign strobe_live = strobe_phase & pins_live;
    assign high_page = in_high_page(access_addr_q);

    // Strobes are only asserted in a live cycle of an expanded mode. Gating them with the
    // standby pin keeps a cut cycle from showing a low strobe on a released control pin.
    always_comb begin
        addr_valid_strobe_n = ~strobe_live;
        rd_strobe_n = ~(strobe_live && !access_wr_q);
        wr_strobe_n = ~(strobe_live && access_wr_q);
        high_page_select_n = ~(pins_live && high_page && state_q != ST_IDLE);
        bus_ctrl_oe = pins_live;
    end

    // The data pins turn round only inside the data phase of a write, so a byte from
    // the far side never meets our own drive.
    assign bidir_byte_bus_out = access_wdata_q;
    assign bidir_byte_bus_oe = {DATA_W{strobe_live && access_wr_q}};

    // Mode 2 lends the low address byte to the port while the bus is idle; the port
    // value is therefore only visible between accesses.
    assign port_lends_low = (mode_q == MODE_EXP_ROM) && (state_q == ST_IDLE);

    // Each address pin picks its source on its own; mode 1 owns all sixteen lines.
    for (genvar i = 0; i < ADDR_W; i++) begin : g_addr_pin
        if (i < $bits(addr_low_port_out)) begin : g_shared
            assign addr_out_bus[i] = port_lends_low ? addr_low_port_out[i]
                                                    : access_addr_q[i];
        end else begin : g_dedicated
            assign addr_out_bus[i] = access_addr_q[i];
        end
        assign addr_out_oe[i] = pins_live;
    end

endmodule : external_bus_pin_control

/* File: src/ext_bus_pkg.sv */
// Package with constants and carrier types for the external bus pin control block.
package ext_bus_pkg;

    // ==========================================================================
    // Widths and address map
    // ==========================================================================
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] HIGH_PAGE_BASE = 16'hFF00;
    localparam int HIGH_PAGE_MSB = 15;
    localparam int HIGH_PAGE_LSB = 8;

    // ==========================================================================
    // Mode select encodings
    // ==========================================================================
    localparam logic [1:0] MODE_EXP_NOROM = 2'h1;
    localparam logic [1:0] MODE_EXP_ROM = 2'h2;
    localparam logic [1:0] MODE_SINGLE = 2'h3;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int MCLK_HZ = 20_000_000;
    localparam int E_CLK_DIV = 8;
    localparam int E_CNT_W = 3;

    // ==========================================================================
    // Carrier types
    // ==========================================================================
    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic ready;
        logic [7:0] rdata;
    } bus_rsp_t;

    typedef struct packed {
        logic [15:0] addr_out_bus;
        logic addr_oe;
        logic addr_valid_strobe_n;
        logic rd_strobe_n;
        logic wr_strobe_n;
        logic high_page_select_n;
        logic high_page_oe;
    } bus_pins_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_DATA = 4'b0100,
        ST_STALL = 4'b1000
    } bus_state_t;

endpackage : ext_bus_pkg

/* File: src/clock_gen.sv */
// System clock and E clock generator driven from the oscillator input.
`timescale 1ns/1ps
module clock_gen #(
    parameter int E_DIV = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    output logic sys_clk_out,
    output logic sys_tick,
    output logic e_clk_out
);
    import ext_bus_pkg::*;

    logic [E_CNT_W-1:0] e_cnt_q;

    // ==========================================================================
    // Half-rate system clock
    // ==========================================================================
    // Toggling on every rising oscillator edge gives half the input frequency.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sys_clk_out <= 1'b0;
        end else if (run) begin
            sys_clk_out <= ~sys_clk_out;
        end
    end

    // A tick on each rising system-clock phase steps the bus sequencer.
    assign sys_tick = run & ~sys_clk_out;

    // ==========================================================================
    // E clock
    // ==========================================================================
    // The E clock divides the system clock further; it is high for half its period.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            e_cnt_q <= '0;
            e_clk_out <= 1'b0;
        end else if (sys_tick) begin
            if (e_cnt_q == E_CNT_W'(E_DIV / 2 - 1)) begin
                e_cnt_q <= '0;
                e_clk_out <= ~e_clk_out;
            end else begin
                e_cnt_q <= e_cnt_q + 1'b1;
            end
        end
    end

endmodule : clock_gen

/* File: tb/ext_bus_checker.sv */
// Concurrent checks on the ports of the external bus pin control block.
`timescale 1ns/1ps
module ext_bus_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire logic hw_standby_n,
    input wire logic nonmask_pin,
    input wire logic nonmask_edge_select,
    input wire logic nonmask_req,
    input wire ext_bus_pkg::bus_rsp_t cpu_rsp,
    input wire logic [15:0] addr_out_bus,
    input wire logic [15:0] addr_out_oe,
    input wire logic [7:0] bidir_byte_bus_oe,
    input wire logic wait_req_n,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic addr_valid_strobe_n,
    input wire logic high_page_select_n,
    input wire logic bus_ctrl_oe,
    input wire logic sys_clk_out,
    input wire logic chip_in_reset,
    input wire logic chip_in_standby,
    input wire logic [1:0] mode_q
);
    import ext_bus_pkg::*;
    logic run_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_busy;
        !rd_strobe_n || !wr_strobe_n;
    endsequence
    sequence s_nmi_edge;
        reset_pin_n && (nonmask_edge_select ? $rose(nonmask_pin) : $fell(nonmask_pin));
    endsequence
    // The divider may restart after a pin reset or standby, so its first edge is skipped.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) run_q <= 1'h0;
        else run_q <= hw_standby_n && reset_pin_n;
    end
    sysclk_half_a: assert property (run_q && hw_standby_n && reset_pin_n |=>
        sys_clk_out != $past(sys_clk_out)) else $error("system clock not halved");
    strobe_excl_a: assert property (!rd_strobe_n |-> wr_strobe_n)
        else $error("read and write strobes both low");
    addr_valid_a: assert property (s_busy |-> !addr_valid_strobe_n &&
        addr_out_oe == 16'hFFFF && bus_ctrl_oe) else $error("address not valid in access");
    high_page_a: assert property (!addr_valid_strobe_n |->
        high_page_select_n == (addr_out_bus[15:8] != 8'hFF)) else $error("high page wrong");
    data_drive_a: assert property (s_busy |->
        bidir_byte_bus_oe == (rd_strobe_n ? 8'hFF : 8'h00)) else $error("data enable wrong");
    stall_hold_a: assert property ((s_busy ##0 !wait_req_n) |=> !cpu_rsp.ready)
        else $error("access ended during wait");
    single_quiet_a: assert property (mode_q == MODE_SINGLE |-> rd_strobe_n &&
        wr_strobe_n && addr_out_oe == 16'h0000 && !bus_ctrl_oe) else $error("bus active");
    standby_off_a: assert property (!hw_standby_n [*2] |-> chip_in_standby &&
        addr_out_oe == 16'h0000 && bidir_byte_bus_oe == 8'h00) else $error("standby drives");
    pin_reset_a: assert property (!reset_pin_n [*2] |-> chip_in_reset &&
        rd_strobe_n && wr_strobe_n) else $error("pin reset not idle");
    nmi_edge_a: assert property (s_nmi_edge |-> ##[1:3] nonmask_req)
        else $error("nonmaskable edge missed");
endmodule : ext_bus_checker

bind external_bus_pin_control ext_bus_checker chk (
    .mclk(mclk), .reset(reset), .reset_pin_n(reset_pin_n), .hw_standby_n(hw_standby_n),
    .nonmask_pin(nonmask_pin), .nonmask_edge_select(nonmask_edge_select),
    .nonmask_req(nonmask_req), .cpu_rsp(cpu_rsp), .addr_out_bus(addr_out_bus),
    .addr_out_oe(addr_out_oe), .bidir_byte_bus_oe(bidir_byte_bus_oe), .wait_req_n(wait_req_n),
    .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
    .addr_valid_strobe_n(addr_valid_strobe_n), .high_page_select_n(high_page_select_n),
    .bus_ctrl_oe(bus_ctrl_oe), .sys_clk_out(sys_clk_out), .chip_in_reset(chip_in_reset),
    .chip_in_standby(chip_in_standby), .mode_q(mode_q)
);

/* File: tb/ext_mem_model.sv */
// Behavioural external memory with a settable wait length on the expanded bus.
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic mclk,
    input wire logic [15:0] addr_out_bus,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic [7:0] bidir_byte_bus_out,
    input wire logic [7:0] bidir_byte_bus_oe,
    input wire logic [3:0] wait_ticks,
    output logic [7:0] rd_data,
    output logic wait_req_n
);
    logic [7:0] mem [256];
    logic [7:0] last_q = 8'h00;
    logic [4:0] cnt_q = 5'h00;
    // Count cycles of an active strobe so the wait is released after two cycles per tick.
    always_ff @(posedge mclk) begin
        if (rd_strobe_n && wr_strobe_n) cnt_q <= 5'h00;
        else if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
    end
    assign wait_req_n = (rd_strobe_n && wr_strobe_n) || cnt_q >= {wait_ticks, 1'h0};
    // Store writes and remember the last read byte; a released bus shows its inverse.
    always_ff @(posedge mclk) begin
        if (!wr_strobe_n && bidir_byte_bus_oe == 8'hFF) begin
            mem[addr_out_bus[7:0]] <= bidir_byte_bus_out;
        end
        if (!rd_strobe_n) last_q <= mem[addr_out_bus[7:0]];
    end
    assign rd_data = !rd_strobe_n ? mem[addr_out_bus[7:0]] : ~last_q;
endmodule : ext_mem_model

/* File: tb/tb_top.sv */
// Self-checking bench for the external bus pin control block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s exp %0h got %0h", n, e, g); end end
module tb_top;
    import ext_bus_pkg::*;
    logic mclk = 1'h0, reset = 1'h1, reset_pin_n = 1'h0, hw_standby_n = 1'h1;
    logic boot_cfg_hi = 1'h1, boot_cfg_lo = 1'h1, nonmask_pin = 1'h0, nonmask_ack = 1'h0;
    logic nonmask_edge_select = 1'h1, nonmask_req, wait_req_n, rd_strobe_n, wr_strobe_n;
    logic addr_valid_strobe_n, high_page_select_n, bus_ctrl_oe, sys_clk_out, e_clk_out;
    logic chip_in_reset, chip_in_standby, seen_hp;
    logic [7:0] addr_low_port_out = 8'hC3, bidir_byte_bus_in, bidir_byte_bus_out;
    logic [7:0] bidir_byte_bus_oe, rd_data, rdat;
    logic [15:0] addr_out_bus, addr_out_oe, seen_addr;
    logic [3:0] wait_ticks = 4'h0;
    logic [1:0] mode_q, seen_rw;
    bus_req_t cpu_req = '0;
    bus_rsp_t cpu_rsp;
    int n_fail = 0, check_count = 0, cyc = 0, lat, k;
    external_bus_pin_control #(.E_DIV(8)) dut (
        .mclk(mclk), .reset(reset), .reset_pin_n(reset_pin_n), .hw_standby_n(hw_standby_n),
        .boot_cfg_hi(boot_cfg_hi), .boot_cfg_lo(boot_cfg_lo), .nonmask_pin(nonmask_pin),
        .nonmask_edge_select(nonmask_edge_select), .nonmask_ack(nonmask_ack),
        .nonmask_req(nonmask_req), .addr_low_port_out(addr_low_port_out), .cpu_req(cpu_req),
        .cpu_rsp(cpu_rsp), .addr_out_bus(addr_out_bus), .addr_out_oe(addr_out_oe),
        .bidir_byte_bus_in(bidir_byte_bus_in), .bidir_byte_bus_out(bidir_byte_bus_out),
        .bidir_byte_bus_oe(bidir_byte_bus_oe), .wait_req_n(wait_req_n),
        .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
        .addr_valid_strobe_n(addr_valid_strobe_n), .high_page_select_n(high_page_select_n),
        .bus_ctrl_oe(bus_ctrl_oe), .sys_clk_out(sys_clk_out), .e_clk_out(e_clk_out),
        .chip_in_reset(chip_in_reset), .chip_in_standby(chip_in_standby), .mode_q(mode_q)
    );
    ext_mem_model mem_model (
        .mclk(mclk), .addr_out_bus(addr_out_bus), .rd_strobe_n(rd_strobe_n),
        .wr_strobe_n(wr_strobe_n), .bidir_byte_bus_out(bidir_byte_bus_out),
        .bidir_byte_bus_oe(bidir_byte_bus_oe), .wait_ticks(wait_ticks), .rd_data(rd_data),
        .wait_req_n(wait_req_n)
    );
    // Each data bit is the design's where it drives, otherwise the memory's.
    assign bidir_byte_bus_in = (bidir_byte_bus_out & bidir_byte_bus_oe)
                             | (rd_data & ~bidir_byte_bus_oe);
    always #25 mclk = ~mclk;
    // A hang is cut short well beyond the few hundred cycles the tests need.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic end_of_test;
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic set_mode(input logic [1:0] m);
        reset_pin_n = 1'h0;
        {boot_cfg_hi, boot_cfg_lo} = m;
        step(3);
        reset_pin_n = 1'h1;
        step(2);
        `CHK("mode", m, mode_q)
        `CHK("addr oe", (m == MODE_SINGLE) ? 16'h0000 : 16'hFFFF, addr_out_oe)
    endtask : set_mode
    // Holds the request until ready, then lets an edge pass so the ready pulse is gone
    // before the next call; lat counts cycles with a strobe not high.
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
        cpu_req = '{1'h1, wr, a, d};
        {lat, k, seen_hp, seen_rw} = '0;
        while (cpu_rsp.ready !== 1'h1 && k < 100) begin
            step(1);
            k++;
            if (!addr_valid_strobe_n) seen_addr = addr_out_bus;
            seen_hp |= !high_page_select_n;
            seen_rw |= {!rd_strobe_n, !wr_strobe_n};
            lat += int'(rd_strobe_n !== 1'h1 || wr_strobe_n !== 1'h1);
        end
        rdat = cpu_rsp.rdata;
        cpu_req.req = 1'h0;
        step(1);
    endtask : access
    task automatic t_bus;
        int s = 0;
        int e = 0;
        set_mode(MODE_EXP_NOROM);
        access(1'h1, 16'h12A5, 8'h5A);
        `CHK("wr addr", 16'h12A5, seen_addr)
        `CHK("wr strobes", 2'h1, seen_rw)
        `CHK("wr page", 1'h0, seen_hp)
        `CHK("wr cycles", 2, lat)
        wait_ticks = 4'h3;
        access(1'h1, 16'hFF40, 8'hA7);
        `CHK("hi page", 1'h1, seen_hp)
        `CHK("wait cycles", 8, lat)
        wait_ticks = 4'h1;
        access(1'h0, 16'hFF40, 8'h00);
        `CHK("rd strobes", 2'h2, seen_rw)
        `CHK("rd data", 8'hA7, rdat)
        `CHK("rd cycles", 4, lat)
        repeat (64) begin
            {seen_rw} = {sys_clk_out, e_clk_out};
            step(1);
            s += int'(!seen_rw[1] && sys_clk_out);
            e += int'(!seen_rw[0] && e_clk_out);
        end
        `CHK("sys rises", 32, s)
        `CHK("e rises", 4, e)
        set_mode(MODE_EXP_ROM);
        `CHK("port low", 8'hC3, addr_out_bus[7:0])
        access(1'h0, 16'h12A5, 8'h00);
        `CHK("mode2 rd", 8'h5A, rdat)
    endtask : t_bus
    task automatic t_misc;
        set_mode(MODE_SINGLE);
        access(1'h0, 16'h12A5, 8'h00);
        `CHK("refused", 0, lat + int'(cpu_rsp.ready === 1'h1))
        for (int s = 0; s < 2; s++) begin
            nonmask_edge_select = s[0];
            nonmask_ack = 1'h1;
            step(1);
            nonmask_ack = 1'h0;
            nonmask_pin = !s[0];
            step(4);
            `CHK("nmi quiet", 1'h0, nonmask_req)
            nonmask_pin = s[0];
            step(4);
            `CHK("nmi req", 1'h1, nonmask_req)
        end
        hw_standby_n = 1'h0;
        step(3);
        `CHK("standby", 1'h1, chip_in_standby)
        hw_standby_n = 1'h1;
        step(2);
    endtask : t_misc
    initial begin
        step(10);
        reset = 1'h0;
        t_bus();
        t_misc();
        end_of_test();
    end
endmodule : tb_top
